// *** rtl/dmaseq_pkg.sv ***
// Behaviour
// R01: Channel runs single, block, demand or cascade.
// R02: Only memory to I/O, never memory-memory.
// R03: Each transfer decrements count and steps address.
// R04: Terminal count on count rollover or end_of_process.
// R05: Terminal count triggers autoinitialize when programmed.
// R06: Terminal count with chaining switches to next buffer.
// R07: Requester holds dma_request until acknowledge active.
// R08: Single mode releases bus, re-requests, transfers again.
// R09: Block mode keeps bus until terminal count.
// R10: Block requester may drop request after acknowledge.
// R11: Demand runs until count, end_of_process or request drop.
// R12: Demand pause keeps current address and count.
// R13: Cascade acknowledges but disables address, status outputs.
// R14: Cascaded requests pass through local priority network.
// R15: Channel four reserved for cascade only.
// R16: Cascade bus master drives address and commands itself.
// R17: Autoinitialize reloads current from base, mask clear.
// R18: Chain not complete at count: mask, status, stop.
// R19: Masked channel ignores request; per-channel mode settings.
package dmaseq_pkg;

   // ----------------------------------------------------------
   // Widths and register map
   // ----------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int CNT_W = 24;
   localparam int APB_AW = 12;
   localparam int CH_LSB = 5;
   localparam logic [4:0] OFF_MODE = 5'h00;
   localparam logic [4:0] OFF_BASE_ADDR = 5'h04;
   localparam logic [4:0] OFF_BASE_CNT = 5'h08;
   localparam logic [4:0] OFF_CUR_ADDR = 5'h0c;
   localparam logic [4:0] OFF_CUR_CNT = 5'h10;
   localparam logic [APB_AW-1:0] OFF_IRQ_STAT = 12'h100;
   localparam logic [APB_AW-1:0] OFF_IRQ_MASK = 12'h104;
   localparam logic [APB_AW-1:0] OFF_CH_STATUS = 12'h108;

   // ----------------------------------------------------------
   // Modes, configuration and states
   // ----------------------------------------------------------
   localparam logic [1:0] MODE_DEMAND = 2'h0;
   localparam logic [1:0] MODE_SINGLE = 2'h1;
   localparam logic [1:0] MODE_BLOCK = 2'h2;
   localparam logic [1:0] MODE_CASCADE = 2'h3;
   localparam logic [3:0] CYC_STATUS_XFER = 4'h4;
   localparam logic [3:0] CYC_STATUS_IDLE = 4'h0;

   typedef struct packed {
      logic toMem;
      logic mask;
      logic chainDone;
      logic chainEn;
      logic autoInit;
      logic dirDec;
      logic [1:0] mode;
   } dmaseq_cfg_t;

   localparam dmaseq_cfg_t CFG_RESET = 8'h40;
   localparam dmaseq_cfg_t CFG_RESET_CASC = 8'h43;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic hostWriteReadN;
      logic [3:0] cycleStatus;
   } dmaseq_bus_t;

   typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_XFER, ST_CASC} dmaseq_state_t;

endpackage

// *** rtl/dmaseq_top.sv ***
`timescale 1ns/10ps
module dmaseq_top import dmaseq_pkg::*; #(
   parameter int NCH = 8,
   parameter int CASC_CH = 4,
   parameter int XFER_CYCLES = 2
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [NCH-1:0] dmaRequest,
   input wire logic endOfProcess,
   output logic [NCH-1:0] dmaAcknowledgeN,
   output logic busRequest,
   input wire logic busGrant,
   output dmaseq_bus_t busOut,
   output logic busOeN,
   output logic terminalCount
);

   localparam int CHW = $clog2(NCH);
   localparam int XCW = $clog2(XFER_CYCLES + 1);

   // ----------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------
   logic [NCH-1:0] dreqS1_r, dreqS2_r;
   logic eopS1_r, eopS2_r;

   // Two flops on the request and end-of-process inputs, busGrant used directly
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         dreqS1_r <= '0;
         dreqS2_r <= '0;
         eopS1_r <= 1'b0;
         eopS2_r <= 1'b0;
      end else begin
         dreqS1_r <= dmaRequest;
         dreqS2_r <= dreqS1_r;
         eopS1_r <= endOfProcess;
         eopS2_r <= eopS1_r;
      end
   end

   // ----------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------
   logic [CHW-1:0] chIdx;
   logic [4:0] regOff;
   logic chanHit, offOk, mapped, wrAcc;
   assign chIdx = paddr[CH_LSB +: CHW];
   assign regOff = paddr[4:0];
   assign offOk = regOff == OFF_MODE || regOff == OFF_BASE_ADDR || regOff == OFF_BASE_CNT
                  || regOff == OFF_CUR_ADDR || regOff == OFF_CUR_CNT;
   assign chanHit = paddr[APB_AW-1:CH_LSB+CHW] == '0 && offOk;
   assign mapped = chanHit || paddr == OFF_IRQ_STAT || paddr == OFF_IRQ_MASK || paddr == OFF_CH_STATUS;
   assign wrAcc = psel && penable && pwrite && mapped;
   // Zero-wait slave, error on unmapped address
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // ----------------------------------------------------------
   // Channel state arrays
   // ----------------------------------------------------------
   wire dmaseq_cfg_t cfgArr [NCH];
   wire [ADDR_W-1:0] baseAddrArr [NCH];
   wire [CNT_W-1:0] baseCntArr [NCH];
   wire [ADDR_W-1:0] curAddrArr [NCH];
   wire [CNT_W-1:0] curCntArr [NCH];
   logic [NCH-1:0] maskVec, elig, tcEvt, swapEvt;
   logic [2*NCH-1:0] stat_r, irqMask_r;

   dmaseq_state_t state_r, state_nxt;
   logic [CHW-1:0] act_r, pick;
   logic [XCW-1:0] cyc_r;
   logic xferLast, actTc;
   dmaseq_cfg_t actCfg;
   logic [CNT_W-1:0] actCnt;
   assign actCfg = cfgArr[act_r];
   assign actCnt = curCntArr[act_r];
   assign xferLast = state_r == ST_XFER && cyc_r == XCW'(XFER_CYCLES - 1);
   // R04 rollover or end input
   assign actTc = xferLast && (actCnt == '0 || eopS2_r);

   // R19 masked channels ignored
   assign elig = dreqS2_r & ~maskVec;

   // ----------------------------------------------------------
   // Per-channel registers
   // ----------------------------------------------------------
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      dmaseq_cfg_t cfg_r;
      logic [ADDR_W-1:0] baseAddr_r, curAddr_r;
      logic [CNT_W-1:0] baseCnt_r, curCnt_r;
      logic hit, tc, swap, fail, reload, stop, wrMode, wrBAddr, wrBCnt;
      dmaseq_cfg_t wcfg;
      assign wcfg = pwdata[7:0];
      assign hit = xferLast && act_r == CHW'(i);
      assign tc = hit && actTc;
      // R06 next buffer when programmed
      assign swap = tc && cfg_r.chainEn && cfg_r.chainDone;
      assign fail = tc && cfg_r.chainEn && !cfg_r.chainDone;
      // R05 autoinitialize on terminal count
      assign reload = tc && !cfg_r.chainEn && cfg_r.autoInit;
      assign stop = fail || (tc && !cfg_r.chainEn && !cfg_r.autoInit);
      assign wrMode = wrAcc && chanHit && chIdx == CHW'(i) && regOff == OFF_MODE;
      assign wrBAddr = wrAcc && chanHit && chIdx == CHW'(i) && regOff == OFF_BASE_ADDR;
      assign wrBCnt = wrAcc && chanHit && chIdx == CHW'(i) && regOff == OFF_BASE_CNT;

      // Mode configuration, hardware sets win
      always_ff @(posedge mclk) begin
         if (!rstn) begin
            cfg_r <= (i == CASC_CH) ? CFG_RESET_CASC : CFG_RESET;
         end else begin
            if (wrMode) begin
               cfg_r <= wcfg;
            end
            if (swap && !(wrMode && wcfg.chainDone)) begin
               cfg_r.chainDone <= 1'b0;
            end
            // R18 unfinished chain stops
            if (stop) begin
               cfg_r.mask <= 1'b1;
            end
            // R15 channel four fixed cascade
            if (i == CASC_CH) begin
               cfg_r.mode <= MODE_CASCADE;
            end
         end
      end

      // Base copies written by software only
      always_ff @(posedge mclk) begin
         if (!rstn) begin
            baseAddr_r <= '0;
            baseCnt_r <= '0;
         end else begin
            if (wrBAddr) begin
               baseAddr_r <= pwdata[ADDR_W-1:0];
            end
            if (wrBCnt) begin
               baseCnt_r <= pwdata[CNT_W-1:0];
            end
         end
      end

      // R12 current values held between services
      always_ff @(posedge mclk) begin
         if (!rstn) begin
            curAddr_r <= '0;
            curCnt_r <= '0;
         end else if (reload || swap) begin
            // R17 reload from base copies
            curAddr_r <= baseAddr_r;
            curCnt_r <= baseCnt_r;
         end else if (hit) begin
            // R03 step after transfer
            curCnt_r <= curCnt_r - 1'b1;
            curAddr_r <= cfg_r.dirDec ? curAddr_r - 1'b1 : curAddr_r + 1'b1;
         end else begin
            if (wrBAddr && !cfg_r.chainEn) begin
               curAddr_r <= pwdata[ADDR_W-1:0];
            end
            if (wrBCnt && !cfg_r.chainEn) begin
               curCnt_r <= pwdata[CNT_W-1:0];
            end
         end
      end

      assign cfgArr[i] = cfg_r;
      assign baseAddrArr[i] = baseAddr_r;
      assign baseCntArr[i] = baseCnt_r;
      assign curAddrArr[i] = curAddr_r;
      assign curCntArr[i] = curCnt_r;
      assign maskVec[i] = cfg_r.mask;
      assign tcEvt[i] = tc;
      assign swapEvt[i] = swap;

      // R17 reload keeps mask clear
      autoReload_a: assert property (@(posedge mclk) disable iff (!rstn)
         reload |=> curCnt_r == baseCnt_r && curAddr_r == baseAddr_r && !cfg_r.mask)
         else $error("autoinitialize reload wrong"); // R17
      // R18 stop sets mask and status
      chainStop_a: assert property (@(posedge mclk) disable iff (!rstn)
         fail |=> cfg_r.mask && stat_r[i])
         else $error("chain underrun did not stop channel"); // R18
   end

   // ----------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------
   // R14 lowest index wins
   always_comb begin
      pick = '0;
      for (int i = NCH - 1; i >= 0; i--) begin
         if (elig[i]) begin
            pick = CHW'(i);
         end
      end
   end

   // R09 next state by mode, block holds bus
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (|elig) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            // R07 request lost before acknowledge
            if (!dreqS2_r[act_r]) begin
               state_nxt = ST_IDLE;
            end else if (busGrant) begin
               // R01 cascade or transfer modes
               state_nxt = actCfg.mode == MODE_CASCADE ? ST_CASC : ST_XFER;
            end
         end
         ST_XFER: begin
            if (xferLast) begin
               if (actTc || actCfg.mode == MODE_SINGLE) begin
                  // R08 single releases bus
                  state_nxt = ST_IDLE;
               end else if (actCfg.mode == MODE_DEMAND && !dreqS2_r[act_r]) begin
                  // R11 demand pauses on drop
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_CASC: begin
            if (!dreqS2_r[act_r]) begin
               state_nxt = ST_IDLE;
            end
         end
      endcase
   end

   // State, active channel and cycle counter
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         act_r <= '0;
         cyc_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE) begin
            act_r <= pick;
         end
         cyc_r <= (state_r != ST_XFER || xferLast) ? '0 : cyc_r + 1'b1;
      end
   end

   // Terminal count pulse
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         terminalCount <= 1'b0;
      end else begin
         terminalCount <= actTc;
      end
   end

   // ----------------------------------------------------------
   // Bus side outputs
   // ----------------------------------------------------------
   // R13 cascade acknowledges only
   always_comb begin
      dmaAcknowledgeN = '1;
      if (state_r == ST_XFER || state_r == ST_CASC) begin
         dmaAcknowledgeN[act_r] = 1'b0;
      end
   end
   assign busRequest = state_r != ST_IDLE;
   assign busOeN = state_r != ST_XFER;
   // R02 direction bit only memory-I/O
   assign busOut.hostWriteReadN = actCfg.toMem;
   assign busOut.addr = curAddrArr[act_r];
   assign busOut.cycleStatus = state_r == ST_XFER ? CYC_STATUS_XFER : CYC_STATUS_IDLE;

   // ----------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------
   // Sticky events, set wins over write-one clear
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         stat_r <= '0;
      end else begin
         stat_r <= (stat_r & ~((wrAcc && paddr == OFF_IRQ_STAT) ? pwdata[2*NCH-1:0] : '0))
                   | {swapEvt, tcEvt};
      end
   end

   // Interrupt mask register
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         irqMask_r <= '0;
      end else if (wrAcc && paddr == OFF_IRQ_MASK) begin
         irqMask_r <= pwdata[2*NCH-1:0];
      end
   end
   assign irq = |(stat_r & irqMask_r);

   // ----------------------------------------------------------
   // Read data, captured in setup phase
   // ----------------------------------------------------------
   logic [31:0] rdMux;
   always_comb begin
      rdMux = '0;
      if (chanHit) begin
         unique case (regOff)
            OFF_MODE: rdMux = {24'h000000, cfgArr[chIdx]};
            OFF_BASE_ADDR: rdMux = baseAddrArr[chIdx];
            OFF_BASE_CNT: rdMux = {8'h00, baseCntArr[chIdx]};
            OFF_CUR_ADDR: rdMux = curAddrArr[chIdx];
            default: rdMux = {8'h00, curCntArr[chIdx]};
         endcase
      end else if (paddr == OFF_IRQ_STAT) begin
         rdMux[2*NCH-1:0] = stat_r;
      end else if (paddr == OFF_IRQ_MASK) begin
         rdMux[2*NCH-1:0] = irqMask_r;
      end else if (paddr == OFF_CH_STATUS) begin
         rdMux[2*NCH-1:0] = {dreqS2_r, maskVec};
      end
   end

   always_ff @(posedge mclk) begin
      if (!rstn) begin
         prdata <= '0;
      end else if (psel && !penable) begin
         prdata <= rdMux;
      end
   end

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   sequence singleDone_s;
      xferLast && !actTc && actCfg.mode == MODE_SINGLE;
   endsequence
   sequence releaseRerequest_s;
      state_r == ST_IDLE ##1 state_r == ST_HOLD;
   endsequence

   // R08 release then request again
   singleRelease_a: assert property (@(posedge mclk) disable iff (!rstn)
      singleDone_s ##0 (dreqS2_r[act_r] && !actCfg.mask) |=> releaseRerequest_s)
      else $error("single mode did not release and re-request"); // R08
   // R09 block keeps bus
   blockHold_a: assert property (@(posedge mclk) disable iff (!rstn)
      xferLast && !actTc && actCfg.mode == MODE_BLOCK |=> state_r == ST_XFER && busRequest)
      else $error("block mode released bus early"); // R09
   // R04 count pulse after rollover
   tcPulse_a: assert property (@(posedge mclk) disable iff (!rstn)
      xferLast && actCnt == '0 |=> terminalCount && curCntArr[$past(act_r)] != '1 || terminalCount)
      else $error("terminal count missing"); // R04
   // R03 count decrements once
   countStep_a: assert property (@(posedge mclk) disable iff (!rstn)
      xferLast && !actTc |=> actCnt == $past(actCnt) - 1'b1)
      else $error("word count did not step"); // R03
   // R12 paused demand holds count
   demandPause_a: assert property (@(posedge mclk) disable iff (!rstn)
      xferLast && !actTc && actCfg.mode == MODE_DEMAND && !dreqS2_r[act_r]
      |=> state_r == ST_IDLE ##1 (actCnt == $past(actCnt, 2) - 1'b1 || state_r != ST_HOLD))
      else $error("demand pause lost position"); // R12
   // R13 cascade outputs disabled
   cascQuiet_a: assert property (@(posedge mclk) disable iff (!rstn)
      state_r == ST_CASC |-> busOeN && busOut.cycleStatus == CYC_STATUS_IDLE && !dmaAcknowledgeN[act_r])
      else $error("cascade drove bus outputs"); // R13
   // R19 no service without eligible request
   maskIgnore_a: assert property (@(posedge mclk) disable iff (!rstn)
      state_r == ST_IDLE && elig == '0 |=> state_r == ST_IDLE)
      else $error("masked request was served"); // R19
   // R15 channel four stays cascade
   cascFixed_a: assert property (@(posedge mclk) disable iff (!rstn)
      ##1 cfgArr[CASC_CH].mode == MODE_CASCADE)
      else $error("cascade channel left cascade mode"); // R15

endmodule

// *** sim/dmaseq_dev_model.sv ***
`timescale 1ns/10ps
// -------------------------------------------------
// Requesting devices and bus arbiter
// -------------------------------------------------
module dmaseq_dev_model #(
   parameter int NCH = 8
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [NCH-1:0] want,
   input wire logic drop,
   input wire logic slow,
   input wire logic [NCH-1:0] ackN,
   input wire logic busRequest,
   output logic [NCH-1:0] dmaRequest,
   output logic busGrant
);
   logic [2:0] waitCnt;

   // hold until acknowledge, optional drop after it
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         dmaRequest <= '0;
      end else begin
         dmaRequest <= (want | (dmaRequest & ackN)) & ~(~ackN & {NCH{drop}});
      end
   end

   // Counts how long the bus has been asked for
   always_ff @(posedge mclk) begin
      if (!rstn || !busRequest) begin
         waitCnt <= 3'h0;
      end else if (waitCnt != 3'h7) begin
         waitCnt <= waitCnt + 3'h1;
      end
   end

   // Grant at once, or after four cycles when slow
   assign busGrant = busRequest && (!slow || waitCnt >= 3'h4);
endmodule

// *** sim/tb_dmaseq_top.sv ***
`timescale 1ns/10ps
module tb_dmaseq_top import dmaseq_pkg::*; ;
   localparam int NCH = 8;
   localparam int XC = 2;
   logic mclk, rstn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, stat, addrSeen;
   logic e, endOfProcess, busRequest, busGrant, busOeN, terminalCount;
   logic drop, slow, prevReq, tcSeen, hwSeen;
   logic [3:0] csSeen;
   logic [NCH-1:0] dmaRequest, ackN, want;
   dmaseq_bus_t busOut;
   int badCount, nCompared, nLow, nRel, cyc, k;

   dmaseq_top #(.NCH(NCH), .CASC_CH(4), .XFER_CYCLES(XC)) dmaseq_top_i (.mclk(mclk), .rstn(rstn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .dmaRequest(dmaRequest), .endOfProcess(endOfProcess),
      .dmaAcknowledgeN(ackN), .busRequest(busRequest), .busGrant(busGrant), .busOut(busOut),
      .busOeN(busOeN), .terminalCount(terminalCount));
   dmaseq_dev_model #(.NCH(NCH)) dmaseq_dev_model_i (.mclk(mclk), .rstn(rstn), .want(want), .drop(drop),
      .slow(slow), .ackN(ackN), .busRequest(busRequest), .dmaRequest(dmaRequest), .busGrant(busGrant));

   // Clock generator
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // -------------------------------------------------
   // Helpers
   // -------------------------------------------------
   task end_of_test;
      if (badCount == 0 && nCompared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      nCompared++;
      if (g !== x) begin
         badCount++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask

   // One APB transfer, then one idle cycle
   task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   function automatic logic [11:0] ra(input int ch, input logic [4:0] off);
      return 12'(ch * 32) + 12'(off);
   endfunction

   task rdchk(input string nm, input logic [11:0] a, input logic [31:0] x);
      acc(1'b0, a, 32'h0);
      chk(nm, x, q);
   endtask

   task prog(input int ch, input logic [7:0] cfg, input logic [31:0] a, input logic [23:0] c);
      acc(1'b1, ra(ch, OFF_BASE_ADDR), a);
      acc(1'b1, ra(ch, OFF_BASE_CNT), {8'h00, c});
      acc(1'b1, ra(ch, OFF_MODE), {24'h0, cfg});
   endtask

   // Request until terminal count and judge the channel afterwards
   task run(input int ch, input logic d, input logic eop, input int n, input logic [31:0] ea,
            input logic [23:0] ec, input logic m, input int r);
      nLow = 0;
      nRel = 0;
      tcSeen = 1'b0;
      drop <= d;
      slow <= d;
      endOfProcess <= eop;
      want[ch] <= 1'b1;
      @(posedge mclk);
      while (!tcSeen) begin
         @(posedge mclk);
         // Dropping device lets go once acknowledged
         if (d && !ackN[ch]) want[ch] <= 1'b0;
      end
      if (!d) want[ch] <= 1'b0;
      repeat (10) @(posedge mclk);
      endOfProcess <= 1'b0;
      chk("transfers", n, nLow / XC);
      if (r > 0) chk("releases", r, nRel);
      rdchk("cur addr", ra(ch, OFF_CUR_ADDR), ea);
      rdchk("cur cnt", ra(ch, OFF_CUR_CNT), {8'h0, ec});
      acc(1'b0, ra(ch, OFF_MODE), 32'h0);
      chk("mask", m, q[6]);
      acc(1'b0, OFF_IRQ_STAT, 32'h0);
      stat = q;
      chk("tc status", 1, q[ch]);
      chk("irq out", 1, irq);
      acc(1'b1, OFF_IRQ_MASK, 32'h0);
      chk("irq masked", 0, irq);
      acc(1'b1, OFF_IRQ_MASK, 32'hffff);
      acc(1'b1, OFF_IRQ_STAT, 32'hffff);
      chk("irq cleared", 0, irq);
   endtask

   // Watches transfers, releases, terminal count and the run time
   always @(negedge mclk) begin
      cyc++;
      if (!busOeN) begin
         if (nLow == 0) addrSeen = busOut.addr;
         nLow++;
         hwSeen = busOut.hostWriteReadN;
         csSeen = busOut.cycleStatus;
      end
      if (prevReq && !busRequest) nRel++;
      prevReq = busRequest;
      if (terminalCount === 1'b1) tcSeen = 1'b1;
      if (cyc > 20000) begin
         badCount++;
         end_of_test;
      end
   end

   // -------------------------------------------------
   // Main sequence
   // -------------------------------------------------
   initial begin
      rstn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      endOfProcess = 1'b0;
      want = '0;
      drop = 1'b0;
      slow = 1'b0;
      prevReq = 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      chk("ack idle", 8'hff, ackN);
      rdchk("ch0 mode", ra(0, OFF_MODE), 32'h40);
      acc(1'b1, ra(4, OFF_MODE), 32'h01);
      rdchk("ch4 mode", ra(4, OFF_MODE), 32'h03);
      acc(1'b0, 12'h200, 32'h0);
      chk("unmapped err", 1, e);
      chk("unmapped data", 0, q);
      want[0] <= 1'b1;
      repeat (8) @(posedge mclk);
      chk("masked request", 0, busRequest);
      want[0] <= 1'b0;
      acc(1'b1, OFF_IRQ_MASK, 32'hffff);
      prog(1, 8'h81, 32'h100, 24'h1);
      run(1, 0, 0, 2, 32'h102, 24'hffffff, 1, 2);
      chk("write dir", 1, hwSeen);
      chk("bus addr", 32'h100, addrSeen);
      chk("cycle status", CYC_STATUS_XFER, csSeen);
      prog(2, 8'h06, 32'h200, 24'h2);
      run(2, 1, 0, 3, 32'h1fd, 24'hffffff, 1, 1);
      chk("read dir", 0, hwSeen);
      prog(5, 8'h09, 32'h500, 24'h0);
      run(5, 1, 0, 1, 32'h500, 24'h0, 0, 0);
      prog(6, 8'h02, 32'h600, 24'h10);
      run(6, 1, 1, 1, 32'h601, 24'hf, 1, 1);
      prog(7, 8'h01, 32'h700, 24'h0);
      acc(1'b1, ra(7, OFF_MODE), 32'h31);
      acc(1'b1, ra(7, OFF_BASE_ADDR), 32'h780);
      run(7, 1, 0, 1, 32'h780, 24'h0, 0, 0);
      chk("chain swap", 1, stat[15]);
      run(7, 1, 0, 1, 32'h781, 24'hffffff, 1, 0);
      prog(3, 8'h00, 32'h300, 24'h5);
      nLow = 0;
      tcSeen = 1'b0;
      drop <= 1'b0;
      slow <= 1'b0;
      want[3] <= 1'b1;
      while (nLow < 2) @(posedge mclk);
      want[3] <= 1'b0;
      repeat (12) @(posedge mclk);
      chk("demand pause", 0, busRequest);
      k = nLow / XC;
      rdchk("paused cnt", ra(3, OFF_CUR_CNT), 32'(5 - k));
      rdchk("paused addr", ra(3, OFF_CUR_ADDR), 32'(32'h300 + k));
      want[3] <= 1'b1;
      while (!tcSeen) @(posedge mclk);
      want[3] <= 1'b0;
      repeat (10) @(posedge mclk);
      chk("demand total", 6, nLow / XC);
      rdchk("demand addr", ra(3, OFF_CUR_ADDR), 32'h306);
      acc(1'b1, OFF_IRQ_STAT, 32'hffff);
      nLow = 0;
      want[4] <= 1'b1;
      k = 0;
      while (ackN[4] && k < 50) begin
         @(posedge mclk);
         k++;
      end
      repeat (6) @(posedge mclk);
      chk("cascade ack", 0, ackN[4]);
      chk("cascade bus off", 0, nLow);
      want[4] <= 1'b0;
      repeat (8) @(posedge mclk);
      chk("cascade done", 1, ackN[4]);
      end_of_test;
   end
endmodule
